/* File: shared/dpr_pkg.sv */
// shared constants, types and helpers for the dual-port memory and its port driver
package dpr_pkg;

  typedef enum logic [2:0]
  {
    DPR_WRITE_FIRST = 3'h1,
    DPR_READ_FIRST = 3'h2,
    DPR_NO_CHANGE = 3'h4
  } dpr_wmode_t;

  typedef enum logic [1:0]
  {
    DPR_CHAIN_NONE = 2'h0,
    DPR_CHAIN_LOWER = 2'h1,
    DPR_CHAIN_UPPER = 2'h2
  } dpr_chain_t;

  typedef enum logic [3:0]
  {
    DPR_U_IDLE = 4'h1,
    DPR_U_ISSUE = 4'h2,
    DPR_U_GATE = 4'h4,
    DPR_U_CAPT = 4'h8
  } dpr_ustate_t;

  // array geometry
  localparam int DPR_FULL_DATA_BITS = 32768;
  localparam int DPR_HALF_DATA_BITS = 16384;
  localparam int DPR_FULL_ABITS = 15;
  localparam int DPR_HALF_ABITS = 14;
  localparam int DPR_CHAIN_ABIT = 15;
  localparam int DPR_BYTE_BITS = 8;
  localparam int DPR_DATA_MAX = 32;
  localparam int DPR_PAR_MAX = 4;
  localparam int DPR_PORT_MAX = 36;
  localparam logic [35:0] DPR_INIT_DEFAULT = 36'h0;
  localparam logic [35:0] DPR_FORCE_DEFAULT = 36'h0;

  // port driver register map (byte addresses)
  localparam logic [7:0] DPR_REG_CTRL = 8'h00;
  localparam logic [7:0] DPR_REG_ADDR = 8'h04;
  localparam logic [7:0] DPR_REG_WDATA = 8'h08;
  localparam logic [7:0] DPR_REG_WPAR = 8'h0C;
  localparam logic [7:0] DPR_REG_RDATA = 8'h10;
  localparam logic [7:0] DPR_REG_RPAR = 8'h14;
  localparam logic [7:0] DPR_REG_STATUS = 8'h18;
  localparam int DPR_CTRL_WRITE_BIT = 0;
  localparam int DPR_CTRL_FORCE_BIT = 1;
  localparam int DPR_CTRL_BE_LSB = 4;
  localparam logic [31:0] DPR_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] DPR_RST_ADDR = 16'h0000;

  function automatic int dpr_data_w(input int w);
    return (w >= 9) ? (w / 9) * DPR_BYTE_BITS : w;
  endfunction

  function automatic int dpr_log2(input int v);
    int r;
    r = 0;
    while ((1 << r) < v)
    begin
      r++;
    end
    return r;
  endfunction

  // spread a port-width value into data lane [31:0] and check lane [35:32]
  function automatic logic [35:0] dpr_split(input logic [35:0] v, input int w);
    logic [35:0] r;
    int dw;
    dw = dpr_data_w(w);
    r = '0;
    for (int i = 0; i < DPR_DATA_MAX; i++)
    begin
      if (i < dw)
        r[i] = v[i];
    end
    for (int j = 0; j < DPR_PAR_MAX; j++)
    begin
      if (j < w - dw)
        r[DPR_DATA_MAX + j] = v[dw + j];
    end
    return r;
  endfunction

endpackage

/* File: shared/dpr_port_if.sv */
// one memory port: the memory end and the driving user logic
`timescale 1ns/1ps
interface dpr_port_if;
  logic en;
  logic [3:0] we;
  logic pipe_stage_gate;
  logic output_force;
  logic [15:0] addr;
  logic [31:0] write_bus;
  logic [3:0] write_check_bits;
  logic [31:0] read_bus;
  logic [3:0] read_check_bits;

  modport mem
  (
    input en,
    input we,
    input pipe_stage_gate,
    input output_force,
    input addr,
    input write_bus,
    input write_check_bits,
    output read_bus,
    output read_check_bits
  );

  modport user
  (
    output en,
    output we,
    output pipe_stage_gate,
    output output_force,
    output addr,
    output write_bus,
    output write_check_bits,
    input read_bus,
    input read_check_bits
  );
endinterface

/* File: logic/dpr_mem_core.sv */
// true dual-port block memory with shared cells, output latches and optional register
//
// What this block does
// - both ports synchronous, one shared cell set
// - disabled port holds latch, writes nothing; register still loads on gate
// - write needs enable and write strobe
// - strobe low on enabled port reads
// - write strobe and gate always active high
// - register captures when gate is 1, or the force value when enabled and forced
// - force loads latch, or register only
// - force never touches cells or writes
// - force acts only while enabled
// - each port has 36-bit force value
// - half array width to address mapping
// - full array width to address mapping
// - chained mode 16-bit address, top bit picks the half
// - data plus check bits equal port width
// - output shows read, new or old data
// - hold mode keeps outputs during write
// - upper chain inputs from lower outputs
// - chip-wide init loads latches, not cells
// - unused data and address tied high
// - one shared half or full array
// - port address, low bits masked, is the cell bit index
// - new mode merges written and old bytes
// - register stage selected 0 or 1
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module dpr_mem_core #(
  parameter bit FULL_SIZE = 1'b1,
  parameter dpr_pkg::dpr_chain_t CHAIN = dpr_pkg::DPR_CHAIN_NONE,
  parameter int WIDTH_A = 36,
  parameter int WIDTH_B = 36,
  parameter dpr_pkg::dpr_wmode_t WMODE_A = dpr_pkg::DPR_WRITE_FIRST,
  parameter dpr_pkg::dpr_wmode_t WMODE_B = dpr_pkg::DPR_WRITE_FIRST,
  parameter logic [1:0] PIPE_STAGE = 2'h0,
  parameter logic [1:0] EN_LOW = 2'h0,
  parameter logic [1:0] FORCE_LOW = 2'h0,
  parameter logic [35:0] INIT_A = dpr_pkg::DPR_INIT_DEFAULT,
  parameter logic [35:0] INIT_B = dpr_pkg::DPR_INIT_DEFAULT,
  parameter logic [35:0] FORCE_VAL_A = dpr_pkg::DPR_FORCE_DEFAULT,
  parameter logic [35:0] FORCE_VAL_B = dpr_pkg::DPR_FORCE_DEFAULT
) (
  // clock and chip-wide init
  input wire logic hclk,
  input wire logic hresetn,
  // memory ports
  dpr_port_if.mem port_a,
  dpr_port_if.mem port_b,
  // chain pins, bit 0 port a, bit 1 port b
  input wire logic [1:0] chain_input_latch,
  input wire logic [1:0] chain_input_register,
  output logic [1:0] chain_output_latch,
  output logic [1:0] chain_output_register
);

  localparam int DATA_BITS = FULL_SIZE ? dpr_pkg::DPR_FULL_DATA_BITS
                                       : dpr_pkg::DPR_HALF_DATA_BITS;
  localparam int PAR_BITS = DATA_BITS / dpr_pkg::DPR_BYTE_BITS;
  localparam int ABITS = FULL_SIZE ? dpr_pkg::DPR_FULL_ABITS : dpr_pkg::DPR_HALF_ABITS;

  logic data_cell [DATA_BITS];
  logic par_cell [PAR_BITS];

  logic [1:0] en_pin;
  logic [1:0] force_pin;
  logic [1:0] gate_pin;
  logic [1:0][3:0] we_pin;
  logic [1:0][3:0] wpar_pin;
  logic [1:0][15:0] addr_pin;
  logic [1:0][31:0] wdata_pin;
  logic [1:0][31:0] dbit_wr;
  logic [1:0][3:0] pbit_wr;
  logic [1:0][14:0] dbase;
  logic [1:0][11:0] pbase;
  logic [1:0][35:0] out_view;

  assign en_pin = {port_b.en, port_a.en};
  assign force_pin = {port_b.output_force, port_a.output_force};
  assign gate_pin = {port_b.pipe_stage_gate, port_a.pipe_stage_gate};
  assign we_pin = {port_b.we, port_a.we};
  assign wpar_pin = {port_b.write_check_bits, port_a.write_check_bits};
  assign addr_pin = {port_b.addr, port_a.addr};
  assign wdata_pin = {port_b.write_bus, port_a.write_bus};

  // data lane and check lane split
  assign port_a.read_bus = out_view[0][31:0];
  assign port_a.read_check_bits = out_view[0][35:32];
  assign port_b.read_bus = out_view[1][31:0];
  assign port_b.read_check_bits = out_view[1][35:32];

  for (genvar p = 0; p < 2; p++)
  begin : g_port
    localparam int W = (p == 0) ? WIDTH_A : WIDTH_B;
    localparam int DW = dpr_pkg::dpr_data_w(W);
    localparam int PW = W - DW;
    localparam int LG = dpr_pkg::dpr_log2(DW);
    localparam bit PIPE = PIPE_STAGE[p];
    localparam dpr_pkg::dpr_wmode_t WM = (p == 0) ? WMODE_A : WMODE_B;
    localparam logic [35:0] FORCE_L = dpr_pkg::dpr_split((p == 0) ? FORCE_VAL_A
                                                                : FORCE_VAL_B, W);
    localparam logic [35:0] INIT_L = dpr_pkg::dpr_split((p == 0) ? INIT_A : INIT_B, W);
    localparam logic [15:0] AMASK = 16'((1 << ABITS) - (1 << LG));

    logic en;
    logic frc;
    logic wr_any;
    logic bank_hit;
    logic do_write;
    logic [35:0] old_word;
    logic [35:0] new_word;
    logic [31:0] wr_d;
    logic [3:0] wr_p;
    logic [35:0] next_latch;
    logic [35:0] latch_q;
    logic [35:0] reg_q;
    logic [35:0] lat_view;
    logic [35:0] reg_view;
    logic sel_lat;
    logic sel_reg;

    assign en = en_pin[p] ^ EN_LOW[p];
    assign frc = force_pin[p] ^ FORCE_LOW[p];
    assign wr_any = |we_pin[p];
    // top address bit picks the chained half
    assign bank_hit = (CHAIN == dpr_pkg::DPR_CHAIN_NONE) ||
                      (addr_pin[p][dpr_pkg::DPR_CHAIN_ABIT] == (CHAIN == dpr_pkg::DPR_CHAIN_UPPER));
    assign do_write = en & wr_any & bank_hit;

    // upper address bits give cell base
    assign dbase[p] = 15'(addr_pin[p] & AMASK);
    assign pbase[p] = 12'(dbase[p] >> 3);

    always_comb
    begin
      old_word = '0;
      new_word = '0;
      wr_d = '0;
      wr_p = '0;
      for (int i = 0; i < dpr_pkg::DPR_DATA_MAX; i++)
      begin
        if (i < DW)
        begin
          old_word[i] = data_cell[dbase[p] + 15'(i)];
          wr_d[i] = do_write & we_pin[p][i / dpr_pkg::DPR_BYTE_BITS];
          new_word[i] = wr_d[i] ? wdata_pin[p][i] : old_word[i];
        end
      end
      for (int j = 0; j < dpr_pkg::DPR_PAR_MAX; j++)
      begin
        if (j < PW)
        begin
          old_word[dpr_pkg::DPR_DATA_MAX + j] = par_cell[pbase[p] + 12'(j)];
          wr_p[j] = do_write & we_pin[p][j];
          new_word[dpr_pkg::DPR_DATA_MAX + j] = wr_p[j] ? wpar_pin[p][j]
                                                        : old_word[dpr_pkg::DPR_DATA_MAX + j];
        end
      end
    end

    assign dbit_wr[p] = wr_d;
    assign pbit_wr[p] = wr_p;

    always_comb
    begin
      next_latch = latch_q;
      if (!en)
        next_latch = latch_q;
      // force hits latch only without register
      else if (frc)
        next_latch = PIPE ? latch_q : FORCE_L;
      else if (wr_any)
      begin
        case (WM)
          dpr_pkg::DPR_WRITE_FIRST: next_latch = new_word;
          dpr_pkg::DPR_READ_FIRST: next_latch = old_word;
          default: next_latch = latch_q;
        endcase
      end
      else
        next_latch = old_word;
    end

    // latch loaded on the same edge that samples enable
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        latch_q <= INIT_L;
        sel_lat <= 1'b1;
      end
      else
      begin
        latch_q <= next_latch;
        if (en)
          sel_lat <= addr_pin[p][dpr_pkg::DPR_CHAIN_ABIT];
      end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        reg_q <= INIT_L;
        sel_reg <= 1'b1;
      end
      else if (PIPE && en && frc)
        reg_q <= FORCE_L;
      else if (PIPE && gate_pin[p])
      begin
        reg_q <= latch_q;
        sel_reg <= sel_lat;
      end
    end

    // upper takes lower half through chain inputs
    assign lat_view = (CHAIN == dpr_pkg::DPR_CHAIN_UPPER && !sel_lat) ?
                      {35'h0, chain_input_latch[p]} : latch_q;
    assign reg_view = (CHAIN == dpr_pkg::DPR_CHAIN_UPPER && !sel_reg) ?
                      {35'h0, chain_input_register[p]} : reg_q;
    assign out_view[p] = PIPE ? reg_view : lat_view;
    assign chain_output_latch[p] = latch_q[0];
    assign chain_output_register[p] = reg_q[0];
  end

  // single write process, force never writes cells
  always_ff @(posedge hclk)
  begin
    for (int p = 0; p < 2; p++)
    begin
      for (int i = 0; i < dpr_pkg::DPR_DATA_MAX; i++)
      begin
        if (dbit_wr[p][i])
          data_cell[dbase[p] + 15'(i)] <= wdata_pin[p][i];
      end
      for (int j = 0; j < dpr_pkg::DPR_PAR_MAX; j++)
      begin
        if (pbit_wr[p][j])
          par_cell[pbase[p] + 12'(j)] <= wpar_pin[p][j];
      end
    end
  end

endmodule

/* File: logic/dpr_user_port.sv */
// user-side driver of one memory port, commanded over an AHB-Lite register slave
`timescale 1ns/1ps
module dpr_user_port #(
  parameter bit PIPE_STAGE = 1'b0,
  parameter bit CHAINED = 1'b0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // memory port
  dpr_port_if.user mp
);

  dpr_pkg::dpr_ustate_t state;
  dpr_pkg::dpr_ustate_t next_state;
  logic a_valid;
  logic a_write;
  logic [7:0] a_addr;
  logic [7:0] ctrl;
  logic [15:0] op_addr;
  logic [31:0] op_wdata;
  logic [3:0] op_wpar;
  logic [31:0] rdata;
  logic [3:0] rpar;
  logic [31:0] rd_word;

  wire take = hsel & hready & htrans[1];
  wire wr_now = a_valid & a_write;
  wire start = wr_now & (a_addr == dpr_pkg::DPR_REG_CTRL) & (state == dpr_pkg::DPR_U_IDLE);
  wire issue = (state == dpr_pkg::DPR_U_ISSUE);
  wire is_wr = ctrl[dpr_pkg::DPR_CTRL_WRITE_BIT];
  wire is_frc = ctrl[dpr_pkg::DPR_CTRL_FORCE_BIT];

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // enable and strobe presented before the edge
  assign mp.en = issue;
  assign mp.we = (issue && is_wr) ? ctrl[dpr_pkg::DPR_CTRL_BE_LSB +: 4] : 4'h0;
  assign mp.output_force = issue & ctrl[dpr_pkg::DPR_CTRL_FORCE_BIT];
  assign mp.pipe_stage_gate = (state == dpr_pkg::DPR_U_GATE);
  // top address bit high unless chained
  assign mp.addr = issue ? {CHAINED ? op_addr[15] : 1'b1, op_addr[14:0]} : 16'hFFFF;
  assign mp.write_bus = issue ? op_wdata : 32'hFFFF_FFFF;
  assign mp.write_check_bits = issue ? op_wpar : 4'hF;

  assign rd_word = (haddr[7:0] == dpr_pkg::DPR_REG_CTRL) ? {24'h0, ctrl} :
                   (haddr[7:0] == dpr_pkg::DPR_REG_ADDR) ? {16'h0, op_addr} :
                   (haddr[7:0] == dpr_pkg::DPR_REG_WDATA) ? op_wdata :
                   (haddr[7:0] == dpr_pkg::DPR_REG_WPAR) ? {28'h0, op_wpar} :
                   (haddr[7:0] == dpr_pkg::DPR_REG_RDATA) ? rdata :
                   (haddr[7:0] == dpr_pkg::DPR_REG_RPAR) ? {28'h0, rpar} :
                   (haddr[7:0] == dpr_pkg::DPR_REG_STATUS) ?
                   {31'h0, state != dpr_pkg::DPR_U_IDLE} : 32'h0;

  always_comb
  begin
    next_state = state;
    case (state)
      dpr_pkg::DPR_U_IDLE: next_state = start ? dpr_pkg::DPR_U_ISSUE : dpr_pkg::DPR_U_IDLE;
      // register stage adds the gated clock, except on a force
      dpr_pkg::DPR_U_ISSUE: next_state = (PIPE_STAGE && !is_frc) ? dpr_pkg::DPR_U_GATE
                                                                 : dpr_pkg::DPR_U_CAPT;
      dpr_pkg::DPR_U_GATE: next_state = dpr_pkg::DPR_U_CAPT;
      dpr_pkg::DPR_U_CAPT: next_state = dpr_pkg::DPR_U_IDLE;
      default: next_state = dpr_pkg::DPR_U_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state <= dpr_pkg::DPR_U_IDLE;
      a_valid <= 1'b0;
      a_write <= 1'b0;
      a_addr <= 8'h00;
      hrdata <= dpr_pkg::DPR_RST_WORD;
    end
    else
    begin
      state <= next_state;
      a_valid <= take;
      a_write <= hwrite;
      a_addr <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rd_word;
    end
  end

  // register writes in the data phase; ctrl ignored while busy
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl <= 8'h00;
      op_addr <= dpr_pkg::DPR_RST_ADDR;
      op_wdata <= dpr_pkg::DPR_RST_WORD;
      op_wpar <= 4'h0;
      rdata <= dpr_pkg::DPR_RST_WORD;
      rpar <= 4'h0;
    end
    else
    begin
      if (start)
        ctrl <= hwdata[7:0];
      if (wr_now && a_addr == dpr_pkg::DPR_REG_ADDR)
        op_addr <= hwdata[15:0];
      if (wr_now && a_addr == dpr_pkg::DPR_REG_WDATA)
        op_wdata <= hwdata;
      if (wr_now && a_addr == dpr_pkg::DPR_REG_WPAR)
        op_wpar <= hwdata[3:0];
      if (state == dpr_pkg::DPR_U_CAPT)
      begin
        rdata <= mp.read_bus;
        rpar <= mp.read_check_bits;
      end
    end
  end

endmodule

/* File: test/dpr_port_sva.sv */
// concurrent checks on memory port a, between its driver and the memory
`timescale 1ns/1ps
module dpr_port_sva #(
  parameter logic [35:0] INIT_A = 36'h0,
  parameter logic [35:0] FORCE_VAL_A = 36'h0
) (
  // clock and init
  input wire logic hclk,
  input wire logic hresetn,
  // port signals
  input wire logic en,
  input wire logic [3:0] we,
  input wire logic output_force,
  input wire logic [15:0] addr,
  input wire logic [31:0] write_bus,
  input wire logic [3:0] write_check_bits,
  input wire logic [31:0] read_bus,
  input wire logic [3:0] read_check_bits
);
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence s_full_wr;
    en && we == 4'hF && !output_force;
  endsequence
  sequence s_byte1_wr;
    en && we == 4'h2 && !output_force;
  endsequence
  sequence s_force;
    en && output_force;
  endsequence
  init_out_a: assert property ($rose(hresetn) |-> {read_check_bits, read_bus} == INIT_A)
    else $error("output not at init value after reset");
  hold_disabled_a: assert property (!en |=> $stable(read_bus) && $stable(read_check_bits))
    else $error("output moved on a disabled edge");
  full_write_a: assert property (s_full_wr |=>
    {read_check_bits, read_bus} == $past({write_check_bits, write_bus}))
    else $error("write-first output differs from written word");
  byte_merge_a: assert property (s_byte1_wr |=> read_bus[15:8] == $past(write_bus[15:8]) &&
    read_check_bits[1] == $past(write_check_bits[1]))
    else $error("written byte not shown on output");
  force_value_a: assert property (s_force |=> {read_check_bits, read_bus} == FORCE_VAL_A)
    else $error("force value not loaded");
  strobe_with_en_a: assert property (we != 4'h0 |-> en)
    else $error("write strobe without enable");
  idle_tied_a: assert property (!en |-> addr == 16'hFFFF && write_bus == 32'hFFFF_FFFF &&
    write_check_bits == 4'hF)
    else $error("idle inputs not tied high");
  top_bit_a: assert property (addr[15])
    else $error("address top bit low without chaining");
endmodule

/* File: test/test_dual_port_block_ram_ports.sv */
// self-checking bench: four port drivers facing two dual-port memories
`timescale 1ns/1ps
module test_dual_port_block_ram_ports;
  localparam logic [35:0] INIT_A = 36'h9_1234_5678;
  localparam logic [35:0] FVAL_A = 36'hC_5A5A_3C3C;
  localparam logic [35:0] FVAL_B = 36'h0_0000_01A5;
  logic hclk;
  logic hresetn;
  logic hsel [4];
  logic [31:0] haddr [4];
  logic [1:0] htrans [4];
  logic hwrite [4];
  logic [31:0] hwdata [4];
  logic hreadyout [4];
  logic [31:0] hrdata [4];
  int bad_count;
  int cmp_count;
  dpr_port_if pa();
  dpr_port_if pb();
  dpr_mem_core #(
    .WIDTH_B(9),
    .WMODE_B(dpr_pkg::DPR_READ_FIRST),
    .INIT_A(INIT_A),
    .FORCE_VAL_A(FVAL_A),
    .FORCE_VAL_B(FVAL_B)
  ) u_dpr_mem_core (
    .hclk(hclk), .hresetn(hresetn), .port_a(pa), .port_b(pb),
    .chain_input_latch(2'h0), .chain_input_register(2'h0),
    .chain_output_latch(), .chain_output_register()
  );
  dpr_user_port u_dpr_user_port_a (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel[0]), .haddr(haddr[0]), .htrans(htrans[0]),
    .hwrite(hwrite[0]), .hsize(3'h2), .hwdata(hwdata[0]), .hready(hreadyout[0]),
    .hreadyout(hreadyout[0]), .hresp(), .hrdata(hrdata[0]), .mp(pa)
  );
  dpr_user_port u_dpr_user_port_b (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel[1]), .haddr(haddr[1]), .htrans(htrans[1]),
    .hwrite(hwrite[1]), .hsize(3'h2), .hwdata(hwdata[1]), .hready(hreadyout[1]),
    .hreadyout(hreadyout[1]), .hresp(), .hrdata(hrdata[1]), .mp(pb)
  );
  // second array: register stage on port a, hold-output mode on port b
  dpr_port_if pc();
  dpr_port_if pd();
  dpr_mem_core #(
    .WMODE_B(dpr_pkg::DPR_NO_CHANGE),
    .PIPE_STAGE(2'h1),
    .FORCE_VAL_A(FVAL_A)
  ) u_dpr_mem_core_pipe (
    .hclk(hclk), .hresetn(hresetn), .port_a(pc), .port_b(pd),
    .chain_input_latch(2'h0), .chain_input_register(2'h0),
    .chain_output_latch(), .chain_output_register()
  );
  dpr_user_port #(.PIPE_STAGE(1'b1)) u_dpr_user_port_c (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel[2]), .haddr(haddr[2]), .htrans(htrans[2]),
    .hwrite(hwrite[2]), .hsize(3'h2), .hwdata(hwdata[2]), .hready(hreadyout[2]),
    .hreadyout(hreadyout[2]), .hresp(), .hrdata(hrdata[2]), .mp(pc)
  );
  dpr_user_port u_dpr_user_port_d (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel[3]), .haddr(haddr[3]), .htrans(htrans[3]),
    .hwrite(hwrite[3]), .hsize(3'h2), .hwdata(hwdata[3]), .hready(hreadyout[3]),
    .hreadyout(hreadyout[3]), .hresp(), .hrdata(hrdata[3]), .mp(pd)
  );
  dpr_port_sva #(.INIT_A(INIT_A), .FORCE_VAL_A(FVAL_A)) u_dpr_port_sva (
    .hclk(hclk), .hresetn(hresetn), .en(pa.en), .we(pa.we), .output_force(pa.output_force),
    .addr(pa.addr), .write_bus(pa.write_bus), .write_check_bits(pa.write_check_bits),
    .read_bus(pa.read_bus), .read_check_bits(pa.read_check_bits)
  );
  task conclude;
    $display("checks %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // single transfer, entered just after a rising edge
  task ahb(input int p, input logic wr, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    hsel[p] <= 1'b1;
    htrans[p] <= 2'h2;
    haddr[p] <= {24'h0, a};
    hwrite[p] <= wr;
    do @(posedge hclk); while (hreadyout[p] !== 1'b1);
    hsel[p] <= 1'b0;
    htrans[p] <= 2'h0;
    hwdata[p] <= wd;
    do @(posedge hclk); while (hreadyout[p] !== 1'b1);
    rd = hrdata[p];
  endtask
  // one memory operation through the driver, returning the port output
  task op(input int p, input logic [31:0] ctrl, input logic [15:0] a, input logic [35:0] wv,
    output logic [35:0] rv);
    logic [31:0] d;
    logic [31:0] s;
    ahb(p, 1'b1, dpr_pkg::DPR_REG_ADDR, {16'h0, a}, d);
    ahb(p, 1'b1, dpr_pkg::DPR_REG_WDATA, wv[31:0], d);
    ahb(p, 1'b1, dpr_pkg::DPR_REG_WPAR, {28'h0, wv[35:32]}, d);
    ahb(p, 1'b1, dpr_pkg::DPR_REG_CTRL, ctrl, d);
    s = 32'h1;
    for (int i = 0; i < 20 && s[0] !== 1'b0; i++)
      ahb(p, 1'b0, dpr_pkg::DPR_REG_STATUS, 32'h0, s);
    if (s[0] !== 1'b0)
    begin
      bad_count++;
      $display("[ERR] %0t busy never cleared", $time);
    end
    ahb(p, 1'b0, dpr_pkg::DPR_REG_RDATA, 32'h0, d);
    ahb(p, 1'b0, dpr_pkg::DPR_REG_RPAR, 32'h0, s);
    rv = {s[3:0], d};
  endtask
  task chk(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task t_regs;
    logic [31:0] d;
    ahb(0, 1'b0, dpr_pkg::DPR_REG_RDATA, 32'h0, d);
    chk({4'h0, d}, {4'h0, dpr_pkg::DPR_RST_WORD});
    ahb(0, 1'b1, 8'h40, 32'hFFFF_FFFF, d);
    ahb(0, 1'b0, 8'h40, 32'h0, d);
    chk({4'h0, d}, 36'h0);
    $display("t_regs done");
  endtask
  // word on port a, byte view on port b at the same cells
  task t_rw;
    logic [35:0] r;
    op(0, 32'hF1, 16'h8040, 36'h5_A5C3_0F96, r);
    chk(r, 36'h5_A5C3_0F96);
    op(0, 32'h0, 16'h8040, 36'h0, r);
    chk(r, 36'h5_A5C3_0F96);
    op(1, 32'h0, 16'h8050, 36'h0, r);
    chk(r, 36'h1_0000_00C3);
    op(1, 32'h11, 16'h8050, 36'h0_0000_003C, r);
    chk(r, 36'h1_0000_00C3);
    op(0, 32'h0, 16'h8040, 36'h0, r);
    chk(r, 36'h1_A53C_0F96);
    $display("t_rw done");
  endtask
  task t_byte;
    logic [35:0] r;
    op(0, 32'h21, 16'h8040, 36'h2_1111_7711, r);
    chk(r, 36'h3_A53C_7796);
    $display("t_byte done");
  endtask
  task t_force;
    logic [35:0] r;
    op(0, 32'h2, 16'h8040, 36'h0, r);
    chk(r, FVAL_A);
    op(0, 32'h0, 16'h8040, 36'h0, r);
    chk(r, 36'h3_A53C_7796);
    op(1, 32'h2, 16'h8050, 36'h0, r);
    chk(r, {3'h0, FVAL_B[8], 24'h0, FVAL_B[7:0]});
    op(1, 32'h0, 16'h8050, 36'h0, r);
    chk(r, 36'h0_0000_003C);
    $display("t_force done");
  endtask
  // register stage on port c, hold-output port d, same cells
  task t_pipe;
    logic [35:0] r;
    op(2, 32'hF1, 16'h8040, 36'h5_A5C3_0F96, r);
    chk(r, 36'h5_A5C3_0F96);
    op(2, 32'h2, 16'h8040, 36'h0, r);
    chk(r, FVAL_A);
    op(3, 32'h0, 16'h8040, 36'h0, r);
    chk(r, 36'h5_A5C3_0F96);
    op(3, 32'hF1, 16'h8040, 36'h0_0000_1111, r);
    chk(r, 36'h5_A5C3_0F96);
    op(2, 32'h0, 16'h8040, 36'h0, r);
    chk(r, 36'h0_0000_1111);
    $display("t_pipe done");
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial
  begin
    #(50 * 5000);
    bad_count++;
    conclude();
  end
  initial
  begin
    bad_count = 0;
    cmp_count = 0;
    hresetn = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      hsel[i] = 1'b0;
      haddr[i] = 32'h0;
      htrans[i] = 2'h0;
      hwrite[i] = 1'b0;
      hwdata[i] = 32'h0;
    end
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_rw();
    t_byte();
    t_force();
    t_pipe();
    conclude();
  end
endmodule
